// >>> src/fttr_top.sv
`timescale 1ns/1ps
module fttr_top
   import fttr_pkg::*;
#(
   parameter int MS_TICK_CYCLES = MS_TICK_CYCLES_DEF,
   parameter int INC_W          = 32
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst,
   // Flow samples, magnitudes in Q.16 base units
   input  wire logic             flow_valid,
   input  wire logic             flow_reverse,
   input  wire logic [INC_W-1:0] mass_inc,
   input  wire logic [INC_W-1:0] vol_inc,
   // Totalizer control and request register writes
   input  wire logic             tot_start,
   input  wire logic             tot_stop,
   input  wire logic             req_write,
   input  wire logic [31:0]      req_data,
   // Unit settings
   input  wire logic [3:0]       mass_unit_setting,
   input  wire logic [3:0]       volume_unit_setting,
   // Nonvolatile save and restore
   input  wire logic             nv_load,
   input  wire logic [2:0]       nv_index,
   input  wire logic [63:0]      nv_value,
   output logic      [63:0]      nv_readback,
   // Input register read port
   input  wire logic             mb_req_valid,
   input  wire logic [15:0]      mb_req_addr,
   input  wire logic [7:0]       mb_req_qty,
   output logic                  mb_req_ready,
   output logic                  mb_resp_valid,
   output logic      [15:0]      mb_resp_data,
   output logic                  mb_resp_last,
   output logic                  mb_resp_error,
   // Status
   output logic                  running
);

   localparam int TW = $clog2(MS_TICK_CYCLES);

   // Accumulators and their next values
   logic signed [63:0] acc_reg  [NUM_TOTALS];
   logic signed [63:0] acc_next [NUM_TOTALS];
   logic        [63:0] dbl      [NUM_TOTALS];
   logic        [63:0] snap_reg [NUM_SLOTS];

   logic signed [63:0] m_ext;
   logic signed [63:0] v_ext;
   logic signed [63:0] m_net;
   logic signed [63:0] v_net;
   logic               sample_run;
   logic               clr_sec;

   // Run timer state
   logic               running_reg;
   logic [TW-1:0]      tick_cnt_reg;
   logic               ms_tick;
   logic [31:0]        run_cnt_reg;
   logic [31:0]        run_time_reg;

   // Read engine state
   fttr_state_t        state_reg;
   logic [4:0]         ptr_reg;
   logic [7:0]         left_reg;
   logic               ready_reg;
   logic               resp_valid_reg;
   logic [15:0]        resp_data_reg;
   logic               resp_last_reg;
   logic               resp_error_reg;
   logic [63:0]        readback_reg;
   logic [16:0]        req_end;
   logic               req_bad;

   // Increments widened to accumulator width, signed by direction
   always_comb begin
      m_ext      = $signed({{(64-INC_W){1'b0}}, mass_inc});
      v_ext      = $signed({{(64-INC_W){1'b0}}, vol_inc});
      m_net      = flow_reverse ? -m_ext : m_ext;
      v_net      = flow_reverse ? -v_ext : v_ext;
      sample_run = flow_valid && running_reg;
      clr_sec    = req_write && req_data[CLR_SEC_BIT];
   end

   // Next value of every total
   always_comb begin
      for (int i = 0; i < NUM_TOTALS; i++) begin
         acc_next[i] = acc_reg[i];
      end
      if (sample_run && !flow_reverse) begin
         acc_next[IDX_FWD_VOL] = acc_reg[IDX_FWD_VOL] + v_ext;
      end
      if (sample_run) begin
         acc_next[IDX_NET_MASS] = acc_reg[IDX_NET_MASS] + m_net;
         acc_next[IDX_NET_VOL]  = acc_reg[IDX_NET_VOL] + v_net;
      end
      if (sample_run && flow_reverse) begin
         acc_next[IDX_REV_MASS] = acc_reg[IDX_REV_MASS] + m_ext;
         acc_next[IDX_REV_VOL]  = acc_reg[IDX_REV_VOL] + v_ext;
      end
      // Secondary totals ignore the run flag; a clear keeps the same-cycle sample
      acc_next[IDX_SEC_MASS] = clr_sec ? 64'sh0000_0000_0000_0000
                                       : acc_reg[IDX_SEC_MASS];
      acc_next[IDX_SEC_VOL]  = clr_sec ? 64'sh0000_0000_0000_0000
                                       : acc_reg[IDX_SEC_VOL];
      if (flow_valid) begin
         acc_next[IDX_SEC_MASS] = acc_next[IDX_SEC_MASS] + m_net;
         acc_next[IDX_SEC_VOL]  = acc_next[IDX_SEC_VOL] + v_net;
      end
   end

   // Per-total storage and unit conversion
   genvar g;
   generate
      for (g = 0; g < NUM_TOTALS; g++) begin : g_total
         fttr_conv_if cif ();

         // No reset: totals must outlive a system reset, restore covers power loss
         always_ff @(posedge clk) begin
            if (nv_load && nv_index == 3'(g)) begin
               acc_reg[g] <= $signed(nv_value);
            end else begin
               acc_reg[g] <= acc_next[g];
            end
         end

         // Odd slots hold mass, the rest volume
         assign cif.raw   = acc_reg[g];
         assign cif.scale = (g == IDX_NET_MASS || g == IDX_REV_MASS || g == IDX_SEC_MASS)
                            ? fttr_mass_scale(mass_unit_setting)
                            : fttr_vol_scale(volume_unit_setting);
         assign dbl[g]    = cif.dbl;

         fttr_to_double u_conv (
            .cv (cif.conv)
         );
      end
   endgenerate

   // Raw value for the save path, one cycle behind the index
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         readback_reg <= 64'h0000_0000_0000_0000;
      end else begin
         readback_reg <= (nv_index < 3'(NUM_TOTALS)) ? 64'(acc_reg[nv_index])
                                                      : {32'h0000_0000, run_time_reg};
      end
   end

   // Millisecond divider, restarted by each start so the first tick is a full ms
   assign ms_tick = (tick_cnt_reg == TW'(MS_TICK_CYCLES - 1));

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tick_cnt_reg <= '0;
      end else if (tot_start || !running_reg || ms_tick) begin
         tick_cnt_reg <= '0;
      end else begin
         tick_cnt_reg <= tick_cnt_reg + TW'(1);
      end
   end

   // Run flag: a start while running restarts, a stop while idle is ignored
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         running_reg <= 1'b0;
      end else if (tot_start) begin
         running_reg <= 1'b1;
      end else if (tot_stop) begin
         running_reg <= 1'b0;
      end
   end

   // Elapsed ms since start, latched into the run time at stop
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         run_cnt_reg  <= RUN_TIME_RST;
         run_time_reg <= RUN_TIME_RST;
      end else if (tot_start) begin
         run_cnt_reg <= RUN_TIME_RST;
      end else if (running_reg && tot_stop) begin
         run_time_reg <= run_cnt_reg;
      end else if (running_reg && ms_tick) begin
         run_cnt_reg <= run_cnt_reg + 32'h0000_0001;
      end
   end

   // Request check: whole span must sit inside the map
   always_comb begin
      req_end = {1'b0, mb_req_addr} + {9'h000, mb_req_qty} - 17'h0_0001;
      req_bad = (mb_req_qty == 8'h00) || (mb_req_qty > MAX_QTY)
                || (mb_req_addr < ADDR_BASE) || (req_end > {1'b0, ADDR_LAST});
   end

   // Word at pointer, high word of each value first
   function automatic logic [15:0] word_at(input logic [63:0] v, input logic [1:0] w);
      return v[(3 - w) * 16 +: 16];
   endfunction

   // Snapshot at accept, so a four-word read never tears a total
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < NUM_SLOTS; i++) begin
            snap_reg[i] <= 64'h0000_0000_0000_0000;
         end
      end else if (state_reg == ST_IDLE && ready_reg && mb_req_valid && !req_bad) begin
         for (int i = 0; i < NUM_TOTALS; i++) begin
            snap_reg[i] <= dbl[i];
         end
         snap_reg[IDX_RUN_TIME] <= {run_time_reg, 32'h0000_0000};
      end
   end

   // Read engine: one word per cycle after accept
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_reg      <= ST_IDLE;
         ptr_reg        <= 5'h00;
         left_reg       <= 8'h00;
         ready_reg      <= 1'b0;
         resp_valid_reg <= 1'b0;
         resp_data_reg  <= 16'h0000;
         resp_last_reg  <= 1'b0;
         resp_error_reg <= 1'b0;
      end else begin
         resp_valid_reg <= 1'b0;
         resp_last_reg  <= 1'b0;
         resp_error_reg <= 1'b0;
         case (state_reg)
            ST_IDLE: begin
               if (ready_reg && mb_req_valid) begin
                  ready_reg <= 1'b0;
                  if (req_bad) begin
                     resp_valid_reg <= 1'b1;
                     resp_last_reg  <= 1'b1;
                     resp_error_reg <= 1'b1;
                     resp_data_reg  <= EXC_ILL_ADDR;
                  end else begin
                     ptr_reg   <= 5'(mb_req_addr - ADDR_BASE);
                     left_reg  <= mb_req_qty;
                     state_reg <= ST_SEND;
                  end
               end else begin
                  ready_reg <= 1'b1;
               end
            end
            ST_SEND: begin
               resp_valid_reg <= 1'b1;
               resp_data_reg  <= word_at(snap_reg[ptr_reg[4:2]], ptr_reg[1:0]);
               resp_last_reg  <= (left_reg == 8'h01);
               ptr_reg        <= ptr_reg + 5'h01;
               left_reg       <= left_reg - 8'h01;
               if (left_reg == 8'h01) begin
                  state_reg <= ST_IDLE;
               end
            end
            default: begin
               state_reg <= ST_IDLE;
               ready_reg <= 1'b0;
            end
         endcase
      end
   end

   // Outputs straight from flops
   assign nv_readback   = readback_reg;
   assign mb_req_ready  = ready_reg;
   assign mb_resp_valid = resp_valid_reg;
   assign mb_resp_data  = resp_data_reg;
   assign mb_resp_last  = resp_last_reg;
   assign mb_resp_error = resp_error_reg;
   assign running       = running_reg;

endmodule

// >>> src/fttr_pkg.sv
package fttr_pkg;

   // Input register map, 16-bit word addresses
   localparam logic [15:0] ADDR_FWD_VOL  = 16'h4B18;
   localparam logic [15:0] ADDR_NET_MASS = 16'h4B1C;
   localparam logic [15:0] ADDR_NET_VOL  = 16'h4B20;
   localparam logic [15:0] ADDR_REV_MASS = 16'h4B24;
   localparam logic [15:0] ADDR_REV_VOL  = 16'h4B28;
   localparam logic [15:0] ADDR_SEC_MASS = 16'h4B2C;
   localparam logic [15:0] ADDR_SEC_VOL  = 16'h4B30;
   localparam logic [15:0] ADDR_RUN_TIME = 16'h4B34;
   localparam logic [15:0] ADDR_BASE     = ADDR_FWD_VOL;
   localparam logic [15:0] ADDR_LAST     = 16'h4B35;

   // Slot index of each value, one slot spans four words
   localparam int NUM_TOTALS   = 7;
   localparam int NUM_SLOTS    = 8;
   localparam int IDX_FWD_VOL  = 0;
   localparam int IDX_NET_MASS = 1;
   localparam int IDX_NET_VOL  = 2;
   localparam int IDX_REV_MASS = 3;
   localparam int IDX_REV_VOL  = 4;
   localparam int IDX_SEC_MASS = 5;
   localparam int IDX_SEC_VOL  = 6;
   localparam int IDX_RUN_TIME = 7;

   // Request register command field
   localparam int          CLR_SEC_BIT  = 8;
   // Read request limits and exception answer
   localparam logic [7:0]  MAX_QTY      = 8'h7D;
   localparam logic [15:0] EXC_ILL_ADDR = 16'h0002;

   // Fixed point and float layout
   localparam int          FRAC_BITS = 16;
   localparam logic [10:0] DBL_BIAS  = 11'h3FF;

   // Run-time timebase
   localparam int TICK_MS           = 1;
   localparam int CLK_PERIOD_NS     = 40;
   localparam int MS_TICK_CYCLES_DEF = (TICK_MS * 1000000) / CLK_PERIOD_NS;

   // Reset values of control state
   localparam logic [31:0] RUN_TIME_RST = 32'h0000_0000;

   // Unit factors, Q16.16, base units kg and l
   localparam logic [31:0] SCALE_ONE   = 32'h0001_0000;
   localparam logic [31:0] SCALE_G     = 32'h03E8_0000;
   localparam logic [31:0] SCALE_MILLI = 32'h0000_0041;
   localparam logic [31:0] SCALE_LB    = 32'h0002_3462;
   localparam logic [31:0] SCALE_GAL   = 32'h0000_43A1;

   typedef enum logic [0:0] {ST_IDLE, ST_SEND} fttr_state_t;

   // Mass unit: 0 kg, 1 g, 2 t, 3 lb
   function automatic logic [31:0] fttr_mass_scale(input logic [3:0] unit);
      logic [31:0] s;
      case (unit)
         4'h1:    s = SCALE_G;
         4'h2:    s = SCALE_MILLI;
         4'h3:    s = SCALE_LB;
         default: s = SCALE_ONE;
      endcase
      return s;
   endfunction

   // Volume unit: 0 l, 1 m3, 2 ml, 3 US gal
   function automatic logic [31:0] fttr_vol_scale(input logic [3:0] unit);
      logic [31:0] s;
      case (unit)
         4'h1:    s = SCALE_MILLI;
         4'h2:    s = SCALE_G;
         4'h3:    s = SCALE_GAL;
         default: s = SCALE_ONE;
      endcase
      return s;
   endfunction

endpackage

// >>> src/fttr_conv_if.sv
`timescale 1ns/1ps
// Raw fixed point total in, converted double out
interface fttr_conv_if;
   logic signed [63:0] raw;
   logic        [31:0] scale;
   logic        [63:0] dbl;
   modport conv (input raw, input scale, output dbl);
   modport user (output raw, output scale, input dbl);
endinterface

// >>> src/fttr_to_double.sv
`timescale 1ns/1ps
module fttr_to_double
   import fttr_pkg::*;
(
   // Conversion channel
   fttr_conv_if.conv cv
);

   logic signed [96:0] prod;
   logic signed [63:0] scaled;
   logic        [63:0] mag;
   logic        [63:0] norm;
   logic        [5:0]  msb;
   logic        [10:0] expo;

   // Scale to the selected unit, then normalise into a double
   always_comb begin
      prod   = cv.raw * $signed({1'b0, cv.scale});
      scaled = prod[FRAC_BITS +: 64];
      mag    = scaled[63] ? 64'(-scaled) : 64'(scaled);
      msb    = 6'h00;
      for (int b = 0; b < 64; b++) begin
         if (mag[b]) begin
            msb = 6'(b);
         end
      end
      norm = mag << (6'h3F - msb);
      expo = DBL_BIAS + 11'(msb) - 11'(FRAC_BITS);
      if (mag == 64'h0000_0000_0000_0000) begin
         cv.dbl = 64'h0000_0000_0000_0000;
      end else begin
         cv.dbl = {scaled[63], expo, norm[62:11]}; // Truncates, no rounding
      end
   end

endmodule

// >>> dv/fttr_top_monitor.sv
`timescale 1ns/1ps
module fttr_top_monitor
   import fttr_pkg::*;
(
   // Clock and reset
   input wire logic        clk,
   input wire logic        rst,
   // Totalizer control
   input wire logic        tot_start,
   input wire logic        tot_stop,
   input wire logic        running,
   // Read port
   input wire logic        mb_req_valid,
   input wire logic [15:0] mb_req_addr,
   input wire logic [7:0]  mb_req_qty,
   input wire logic        mb_req_ready,
   input wire logic        mb_resp_valid,
   input wire logic [15:0] mb_resp_data,
   input wire logic        mb_resp_last,
   input wire logic        mb_resp_error
);
   logic        take;
   logic        bad;
   logic [16:0] req_end;

   // Request sorting; end kept one bit wider so a wrap cannot hide
   assign take    = mb_req_valid & mb_req_ready;
   assign req_end = {1'b0, mb_req_addr} + {9'h000, mb_req_qty};
   assign bad     = (mb_req_qty == 8'h00) || (mb_req_qty > MAX_QTY) ||
                    (mb_req_addr < ADDR_BASE) || (req_end > {1'b0, ADDR_LAST} + 17'h0_0001);

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   // Steps of a four-word answer
   sequence s_take4;
      take && !bad && mb_req_qty == 8'h04;
   endsequence
   sequence s_burst4;
      (mb_resp_valid && !mb_resp_last)[*3] ##1 (mb_resp_valid && mb_resp_last);
   endsequence

   property p_burst4;
      s_take4 |=> !mb_resp_valid ##1 s_burst4;
   endproperty
   a_burst4: assert property (p_burst4) else $error("bad burst");
   property p_accept;
      take && !bad |=> !mb_resp_valid ##1 (mb_resp_valid && !mb_resp_error);
   endproperty
   a_accept: assert property (p_accept) else $error("good request refused");
   property p_refuse;
      take && bad |=> mb_resp_valid && mb_resp_error && mb_resp_last && mb_resp_data == EXC_ILL_ADDR;
   endproperty
   a_refuse: assert property (p_refuse) else $error("bad request accepted");
   property p_gap;
      mb_resp_last |-> !mb_req_ready ##1 mb_req_ready;
   endproperty
   a_gap: assert property (p_gap) else $error("ready timing");
   property p_busy;
      mb_resp_valid |-> !mb_req_ready;
   endproperty
   a_busy: assert property (p_busy) else $error("ready during answer");
   property p_start;
      tot_start |=> running;
   endproperty
   a_start: assert property (p_start) else $error("start ignored");
   property p_stop;
      tot_stop && !tot_start && running |=> !running;
   endproperty
   a_stop: assert property (p_stop) else $error("stop ignored");
   property p_run_cause;
      $rose(running) |-> $past(tot_start);
   endproperty
   a_run_cause: assert property (p_run_cause) else $error("run without start");
endmodule

// >>> dv/fttr_master_model.sv
`timescale 1ns/1ps
module fttr_master_model (
   // Clock
   input  wire logic        clk,
   // Request
   output logic             mb_req_valid,
   output logic [15:0]      mb_req_addr,
   output logic [7:0]       mb_req_qty,
   // Answer
   input  wire logic        mb_req_ready,
   input  wire logic        mb_resp_valid,
   input  wire logic [15:0] mb_resp_data,
   input  wire logic        mb_resp_last,
   input  wire logic        mb_resp_error,
   // Collected words, newest lowest
   output logic [63:0]      rd_words,
   output logic             rd_err
);
   initial begin
      mb_req_valid = 1'b0;
      mb_req_addr  = 16'h0000;
      mb_req_qty   = 8'h00;
   end

   // One whole request held until taken; released lines show inverted garbage
   task automatic read(input logic [15:0] a, input logic [7:0] q, input int slow);
      rd_words = 64'h0;
      rd_err = 1'b0;
      repeat (slow) @(negedge clk);
      @(negedge clk);
      mb_req_valid = 1'b1;
      mb_req_addr = a;
      mb_req_qty = q;
      // Ready is looked at off the edge, where it has settled
      while (mb_req_ready !== 1'b1) @(negedge clk);
      @(posedge clk);
      @(negedge clk);
      mb_req_valid = 1'b0;
      mb_req_addr = ~a;
      mb_req_qty = ~q;
      // Answer words are taken mid-cycle, while each one stands
      repeat (200) begin
         if (mb_resp_valid === 1'b1) begin
            rd_words = {rd_words[47:0], mb_resp_data};
            rd_err = mb_resp_error;
            if (mb_resp_last === 1'b1) break;
         end
         @(negedge clk);
      end
   endtask
endmodule

// >>> dv/fttr_top_test.sv
`timescale 1ns/1ps
module fttr_top_test
   import fttr_pkg::*;
;
   logic        clk, rst, flow_valid, flow_reverse, tot_start, tot_stop, req_write, nv_load;
   logic [31:0] mass_inc, vol_inc, req_data;
   logic [3:0]  mass_unit_setting, volume_unit_setting;
   logic [2:0]  nv_index;
   logic [63:0] nv_value, nv_readback, rd_words;
   logic        mb_req_valid, mb_req_ready, mb_resp_valid, mb_resp_last, mb_resp_error;
   logic        running, rd_err;
   logic [15:0] mb_req_addr, mb_resp_data;
   logic [7:0]  mb_req_qty;
   int          num_errors, compares;
   logic [23:0] bad_req [4] = '{{ADDR_BASE, 8'h00}, {16'h4B17, 8'h01},
                                {ADDR_RUN_TIME, 8'h03}, {ADDR_BASE, 8'h7E}};

   fttr_top #(.MS_TICK_CYCLES(10)) fttr_top_i (.clk, .rst, .flow_valid, .flow_reverse,
      .mass_inc, .vol_inc, .tot_start, .tot_stop, .req_write, .req_data, .mass_unit_setting,
      .volume_unit_setting, .nv_load, .nv_index, .nv_value, .nv_readback, .mb_req_valid,
      .mb_req_addr, .mb_req_qty, .mb_req_ready, .mb_resp_valid, .mb_resp_data,
      .mb_resp_last, .mb_resp_error, .running);
   fttr_master_model fttr_master_model_i (.clk, .mb_req_valid, .mb_req_addr, .mb_req_qty,
      .mb_req_ready, .mb_resp_valid, .mb_resp_data, .mb_resp_last, .mb_resp_error,
      .rd_words, .rd_err);

   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      compares++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] %0t got %h want %h", $time, seen, exp);
      end
   endtask

   task automatic final_report;
      $display("compares %0d errors %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // Control strobes for one cycle
   task automatic ctl(input logic s, input logic p, input logic w, input logic [31:0] d);
      @(negedge clk);
      {tot_start, tot_stop, req_write, req_data} = {s, p, w, d};
      @(negedge clk);
      {tot_start, tot_stop, req_write} = 3'h0;
   endtask

   task automatic flow(input logic rev, input logic [31:0] m, input logic [31:0] v);
      @(negedge clk);
      {flow_valid, flow_reverse, mass_inc, vol_inc} = {1'b1, rev, m, v};
      @(negedge clk);
      flow_valid = 1'b0;
   endtask

   // Whole total in one request, compared as a double
   task automatic rd_dbl(input logic [15:0] a, input real r);
      fttr_master_model_i.read(a, 8'h04, 0);
      check(rd_words, $realtobits(r));
   endtask

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // Whole run is a few hundred cycles; this bound only catches a hang
   initial begin
      repeat (5000) @(posedge clk);
      num_errors++;
      final_report;
   end

   initial begin
      {rst, flow_valid, flow_reverse, tot_start, tot_stop, req_write, nv_load} = 7'h40;
      {mass_inc, vol_inc, req_data, nv_value} = '0;
      {mass_unit_setting, volume_unit_setting, nv_index} = 11'h000;
      {num_errors, compares} = '0;
      repeat (10) @(negedge clk);
      rst = 1'b0;
      // Totals power up unknown, restore them all to zero
      for (int i = 0; i < NUM_TOTALS; i++) begin
         @(negedge clk);
         {nv_load, nv_index} = {1'b1, i[2:0]};
      end
      @(negedge clk);
      nv_load = 1'b0;
      ctl(1'b1, 1'b0, 1'b0, 32'h0);
      flow(1'b0, 32'h0002_0000, 32'h0003_0000);
      flow(1'b1, 32'h0001_0000, 32'h0000_8000);
      repeat (31) @(negedge clk);
      ctl(1'b0, 1'b1, 1'b0, 32'h0);
      fttr_master_model_i.read(ADDR_RUN_TIME, 8'h02, 3);
      check(rd_words, 64'h3);
      rd_dbl(ADDR_FWD_VOL, 3.0);
      rd_dbl(ADDR_NET_MASS, 1.0);
      rd_dbl(ADDR_NET_VOL, 2.5);
      rd_dbl(ADDR_REV_MASS, 1.0);
      rd_dbl(ADDR_REV_VOL, 0.5);
      rd_dbl(ADDR_SEC_MASS, 1.0);
      rd_dbl(ADDR_SEC_VOL, 2.5);
      nv_index = 3'h2;
      repeat (2) @(negedge clk);
      check(nv_readback, 64'h0000_0000_0002_8000);
      // Stopped: only the secondary totals move
      flow(1'b0, 32'h0002_0000, 32'h0001_0000);
      rd_dbl(ADDR_FWD_VOL, 3.0);
      rd_dbl(ADDR_SEC_MASS, 3.0);
      rd_dbl(ADDR_SEC_VOL, 3.5);
      ctl(1'b0, 1'b0, 1'b1, 32'h0000_00FF);
      rd_dbl(ADDR_SEC_MASS, 3.0);
      ctl(1'b0, 1'b0, 1'b1, 32'h0000_0100);
      rd_dbl(ADDR_SEC_VOL, 0.0);
      rd_dbl(ADDR_NET_MASS, 1.0);
      @(negedge clk);
      {mass_unit_setting, volume_unit_setting} = 8'h12;
      rd_dbl(ADDR_NET_MASS, 1000.0);
      rd_dbl(ADDR_REV_VOL, 500.0);
      {mass_unit_setting, volume_unit_setting} = 8'h00;
      // Reset in mid-run must not touch the totals
      ctl(1'b1, 1'b0, 1'b0, 32'h0);
      rst = 1'b1;
      repeat (3) @(negedge clk);
      rst = 1'b0;
      rd_dbl(ADDR_NET_VOL, 2.5);
      foreach (bad_req[i]) begin
         fttr_master_model_i.read(bad_req[i][23:8], bad_req[i][7:0], i);
         check({rd_err, rd_words[15:0]}, {1'b1, EXC_ILL_ADDR});
      end
      fttr_master_model_i.read(ADDR_LAST, 8'h01, 0);
      check({rd_err, rd_words[62:0]}, 64'h0);
      final_report;
   end
endmodule

bind fttr_top fttr_top_monitor fttr_top_monitor_i (.clk, .rst, .tot_start, .tot_stop,
   .running, .mb_req_valid, .mb_req_addr, .mb_req_qty, .mb_req_ready, .mb_resp_valid,
   .mb_resp_data, .mb_resp_last, .mb_resp_error);
